// file: hdl/swr_pkg.sv
// Purpose: Shared constants and types for the standby wake request control
// Assumes: 8-bit byte address, 32-bit data, one word per register
// Notes: Offsets are byte addresses on the plain register port
package swr_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_WAKE_C = 8'h00;
    localparam logic [7:0] ADDR_WAKE_D = 8'h04;
    localparam logic [7:0] ADDR_CLEAR = 8'h08;
    localparam logic [7:0] ADDR_NMI = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

    // Wake mode register layout
    localparam int LVL_LSB = 4;
    localparam int LVL_MSB = 6;
    localparam int SEEN_LSB = 2;
    localparam int SEEN_MSB = 3;
    localparam int EN_BIT = 0;
    localparam logic [31:0] MODE_RESET = 32'h2020_2020;
    localparam logic [31:0] MODE_WR_MASK = 32'h7171_7171;

    // Active level selection codes
    localparam logic [2:0] LVL_LOW = 3'h0;
    localparam logic [2:0] LVL_HIGH = 3'h1;
    localparam logic [2:0] LVL_FALL = 3'h2;
    localparam logic [2:0] LVL_RISE = 3'h3;
    localparam logic [2:0] LVL_BOTH = 3'h4;

    // Detected edge codes
    localparam logic [1:0] SEEN_NONE = 2'h0;
    localparam logic [1:0] SEEN_RISE = 2'h1;
    localparam logic [1:0] SEEN_FALL = 2'h2;

    // Request clear codes
    localparam int CLR_MSB = 4;
    localparam logic [4:0] CLR_EXT0 = 5'h00;
    localparam logic [4:0] CLR_EXT1 = 5'h01;
    localparam logic [4:0] CLR_EXT2 = 5'h02;
    localparam logic [4:0] CLR_EXT3 = 5'h03;
    localparam logic [4:0] CLR_EXT4 = 5'h04;
    localparam logic [4:0] CLR_CEC_RX = 5'h06;
    localparam logic [4:0] CLR_REMOTE_RX = 5'h07;
    localparam logic [4:0] CLR_RTC = 5'h08;
    localparam logic [4:0] CLR_CEC_TX = 5'h0c;
    localparam int OTHER_CLR_W = 7;

    // NMI flag positions
    localparam int NMI_WDT_BIT = 0;
    localparam int NMI_PIN_BIT = 1;

    // Interrupt status and mask layout
    localparam int IRQ_W = 4;
    localparam int IRQ_RTC = 0;
    localparam int IRQ_CEC_TX = 1;
    localparam int IRQ_NMI_PIN = 2;
    localparam int IRQ_NMI_WDT = 3;

    typedef struct packed {
        logic pending;
        logic [1:0] edge_seen;
        logic hit;
    } swr_wake_stat_t;
endpackage

// file: hdl/swr_wake_src.sv
// Purpose: One wake request source: level/edge detect, pending, edge record
// Assumes: Source line is synchronous to ref_clk_in
// Notes: Instantiated once each for the RTC and CEC transmit wake sources
`timescale 1ns/1ps
module swr_wake_src (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [2:0] level_sel_in,
    input wire logic enable_in,
    input wire logic src_in,
    input wire logic clear_in,
    output swr_pkg::swr_wake_stat_t stat_out
);
    logic src_d_r;
    logic pending_r;
    logic pending_nxt;
    logic [1:0] seen_r;
    logic [1:0] seen_nxt;
    logic rise;
    logic fall;
    logic match;
    logic hit;
    logic both_mode;

    assign rise = src_in & ~src_d_r;
    assign fall = ~src_in & src_d_r;
    assign both_mode = (level_sel_in == swr_pkg::LVL_BOTH);
    assign match = (level_sel_in == swr_pkg::LVL_LOW) ? ~src_in :
                   (level_sel_in == swr_pkg::LVL_HIGH) ? src_in :
                   (level_sel_in == swr_pkg::LVL_FALL) ? fall :
                   (level_sel_in == swr_pkg::LVL_RISE) ? rise :
                   both_mode ? (rise | fall) : 1'b0;
    assign hit = match & enable_in;
    // A new request in the clear cycle survives
    assign pending_nxt = hit | (pending_r & ~clear_in);
    // Edge only recorded in both-edges mode
    assign seen_nxt = (hit && both_mode) ?
                      (rise ? swr_pkg::SEEN_RISE : swr_pkg::SEEN_FALL) :
                      clear_in ? swr_pkg::SEEN_NONE : seen_r;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            src_d_r <= 1'b0;
            pending_r <= 1'b0;
            seen_r <= 2'h0;
        end else begin
            src_d_r <= src_in;
            pending_r <= pending_nxt;
            seen_r <= seen_nxt;
        end
    end

    // One driver for the whole struct keeps the output a single net
    assign stat_out = '{pending: pending_r, edge_seen: seen_r, hit: hit};
endmodule

// file: hdl/swr_ctrl.sv
// Purpose: Standby wake request control registers and NMI source flags
// Assumes: One clock, synchronous inputs, plain register port
// Notes: Unmapped reads return zero, unmapped writes are ignored
// Functional notes
// - RTC detected-edge field at bits 3-2 is read-only status
// - CEC transmit detected-edge field at bits 3-2 is read-only status
// - Detected-edge field only meaningful in both-edges level mode
// - Clearing a wake request also zeroes its detected-edge field
// - 5-bit clear code selects which source's pending request clears
// - NMI flag bit 1 marks pin source, bit 0 watchdog source
// - Reading NMI flag register clears both flags
`timescale 1ns/1ps
module swr_ctrl (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic rtc_interrupt_in,
    input wire logic cec_transmit_interrupt_in,
    input wire logic nmi_pin_in,
    input wire logic nmi_watchdog_in,
    output logic [31:0] rd_data_out,
    output logic rtc_wake_req_out,
    output logic cec_tx_wake_req_out,
    output logic [6:0] other_clear_out,
    output logic irq_out
);
    logic [31:0] mode_c_r;
    logic [31:0] mode_d_r;
    logic [1:0] nmi_flags_r;
    logic [1:0] nmi_flags_nxt;
    logic [3:0] irq_stat_r;
    logic [3:0] irq_stat_nxt;
    logic [3:0] irq_mask_r;
    logic [31:0] rd_data_r;
    logic rtc_wake_r;
    logic cec_wake_r;
    logic [6:0] other_clear_r;
    logic irq_r;

    swr_pkg::swr_wake_stat_t rtc_stat;
    swr_pkg::swr_wake_stat_t cec_stat;

    wire sel_c = (addr_in == swr_pkg::ADDR_WAKE_C);
    wire sel_d = (addr_in == swr_pkg::ADDR_WAKE_D);
    wire sel_clr = (addr_in == swr_pkg::ADDR_CLEAR);
    wire sel_nmi = (addr_in == swr_pkg::ADDR_NMI);
    wire sel_stat = (addr_in == swr_pkg::ADDR_IRQ_STAT);
    wire sel_mask = (addr_in == swr_pkg::ADDR_IRQ_MASK);

    wire wr_c = wr_en_in & sel_c;
    wire wr_d = wr_en_in & sel_d;
    wire wr_clr = wr_en_in & sel_clr;
    wire wr_stat = wr_en_in & sel_stat;
    wire wr_mask = wr_en_in & sel_mask;
    wire rd_nmi = rd_en_in & sel_nmi;

    wire [2:0] rtc_wake_level_sel =
        mode_c_r[swr_pkg::LVL_MSB:swr_pkg::LVL_LSB];
    wire rtc_wake_en = mode_c_r[swr_pkg::EN_BIT];
    wire [2:0] cec_tx_wake_level_sel =
        mode_d_r[swr_pkg::LVL_MSB:swr_pkg::LVL_LSB];
    wire cec_tx_wake_en = mode_d_r[swr_pkg::EN_BIT];
    wire [1:0] rtc_wake_edge_seen = rtc_stat.edge_seen;
    wire [1:0] cec_tx_wake_edge_seen = cec_stat.edge_seen;

    // Clear code decode; reserved and prohibited codes match nothing
    wire [4:0] wake_req_clear_code = wr_data_in[swr_pkg::CLR_MSB:0];
    wire clr_rtc = wr_clr &&
        (wake_req_clear_code == swr_pkg::CLR_RTC);
    wire clr_cec_tx = wr_clr &&
        (wake_req_clear_code == swr_pkg::CLR_CEC_TX);
    wire [6:0] other_clear_nxt = {
        wr_clr && (wake_req_clear_code == swr_pkg::CLR_REMOTE_RX),
        wr_clr && (wake_req_clear_code == swr_pkg::CLR_CEC_RX),
        wr_clr && (wake_req_clear_code == swr_pkg::CLR_EXT4),
        wr_clr && (wake_req_clear_code == swr_pkg::CLR_EXT3),
        wr_clr && (wake_req_clear_code == swr_pkg::CLR_EXT2),
        wr_clr && (wake_req_clear_code == swr_pkg::CLR_EXT1),
        wr_clr && (wake_req_clear_code == swr_pkg::CLR_EXT0)
    };

    swr_wake_src u_rtc_src (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .level_sel_in(rtc_wake_level_sel),
        .enable_in(rtc_wake_en),
        .src_in(rtc_interrupt_in),
        .clear_in(clr_rtc),
        .stat_out(rtc_stat)
    );

    swr_wake_src u_cec_tx_src (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .level_sel_in(cec_tx_wake_level_sel),
        .enable_in(cec_tx_wake_en),
        .src_in(cec_transmit_interrupt_in),
        .clear_in(clr_cec_tx),
        .stat_out(cec_stat)
    );

    // Set wins over the read that clears, so no NMI is lost
    wire [1:0] nmi_set = {nmi_pin_in, nmi_watchdog_in};
    assign nmi_flags_nxt = nmi_set |
        (nmi_flags_r & {2{~rd_nmi}});

    wire [3:0] irq_events = {nmi_watchdog_in, nmi_pin_in,
                             cec_stat.hit, rtc_stat.hit};
    assign irq_stat_nxt = irq_events |
        (irq_stat_r & ~({4{wr_stat}} & wr_data_in[3:0]));

    // Read views; reserved bits and the clear register read zero
    wire [31:0] mode_c_view = (mode_c_r & swr_pkg::MODE_WR_MASK) |
        {28'h0, rtc_wake_edge_seen, 2'h0};
    wire [31:0] mode_d_view = (mode_d_r & swr_pkg::MODE_WR_MASK) |
        {28'h0, cec_tx_wake_edge_seen, 2'h0};
    wire [31:0] rd_mux = sel_c ? mode_c_view :
                         sel_d ? mode_d_view :
                         sel_nmi ? {30'h0, nmi_flags_r} :
                         sel_stat ? {28'h0, irq_stat_r} :
                         sel_mask ? {28'h0, irq_mask_r} :
                         32'h0;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_c_r <= swr_pkg::MODE_RESET;
            mode_d_r <= swr_pkg::MODE_RESET;
        end else begin
            // Writable groups kept so they read back
            if (wr_c) begin
                mode_c_r <= wr_data_in & swr_pkg::MODE_WR_MASK;
            end
            if (wr_d) begin
                mode_d_r <= wr_data_in & swr_pkg::MODE_WR_MASK;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            nmi_flags_r <= 2'h0;
            irq_stat_r <= 4'h0;
            irq_mask_r <= 4'h0;
        end else begin
            nmi_flags_r <= nmi_flags_nxt;
            irq_stat_r <= irq_stat_nxt;
            if (wr_mask) begin
                irq_mask_r <= wr_data_in[3:0];
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_r <= 32'h0;
            rtc_wake_r <= 1'b0;
            cec_wake_r <= 1'b0;
            other_clear_r <= 7'h0;
            irq_r <= 1'b0;
        end else begin
            rd_data_r <= rd_en_in ? rd_mux : 32'h0;
            rtc_wake_r <= rtc_stat.pending;
            cec_wake_r <= cec_stat.pending;
            other_clear_r <= other_clear_nxt;
            // One cycle behind the status, traded for a flopped output
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign rd_data_out = rd_data_r;
    assign rtc_wake_req_out = rtc_wake_r;
    assign cec_tx_wake_req_out = cec_wake_r;
    assign other_clear_out = other_clear_r;
    assign irq_out = irq_r;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence nmi_read_quiet;
        rd_nmi && !nmi_pin_in && !nmi_watchdog_in;
    endsequence

    sequence rtc_clear_quiet;
        clr_rtc && !rtc_stat.hit;
    endsequence

    nmi_pin_flag_a: assert property (
        nmi_pin_in |=> nmi_flags_r[swr_pkg::NMI_PIN_BIT])
        else $error("NMI pin flag not set");

    nmi_wdt_flag_a: assert property (
        nmi_watchdog_in |=> nmi_flags_r[swr_pkg::NMI_WDT_BIT])
        else $error("NMI watchdog flag not set");

    nmi_read_clear_a: assert property (
        nmi_read_quiet |=> (nmi_flags_r == 2'h0) &&
        (rd_data_out[1:0] == $past(nmi_flags_r)))
        else $error("NMI flags not cleared by read");

    clear_reads_zero_a: assert property (
        rd_en_in && sel_clr |=> rd_data_out == 32'h0)
        else $error("Request clear register read nonzero");

    clear_edge_seen_a: assert property (
        rtc_clear_quiet |=> !rtc_stat.pending &&
        rtc_stat.edge_seen == swr_pkg::SEEN_NONE ##1 !rtc_wake_req_out)
        else $error("RTC clear left request or edge record");

    rtc_seen_read_a: assert property (
        rd_en_in && sel_c |=> rd_data_out[3:2] == $past(rtc_wake_edge_seen)
        && rd_data_out[31] == 1'b0 && rd_data_out[1] == 1'b0)
        else $error("RTC edge record misread");

    cec_seen_read_a: assert property (
        rd_en_in && sel_d |=>
        rd_data_out[3:2] == $past(cec_tx_wake_edge_seen))
        else $error("CEC transmit edge record misread");

    seen_both_only_a: assert property (
        rtc_stat.hit && rtc_wake_level_sel != swr_pkg::LVL_BOTH && !clr_rtc
        |=> $stable(rtc_stat.edge_seen))
        else $error("Edge record changed outside both-edges mode");

    code_decode_a: assert property (
        wr_clr && wake_req_clear_code == swr_pkg::CLR_CEC_RX
        |=> other_clear_out == 7'h20 ##1 other_clear_out == 7'h00
        || $past(wr_clr))
        else $error("CEC receive clear code misdecoded");

    reserved_code_a: assert property (
        wr_clr && (wake_req_clear_code == 5'h05 ||
        (wake_req_clear_code >= 5'h09 && wake_req_clear_code <= 5'h0b))
        |=> other_clear_out == 7'h00)
        else $error("Reserved clear code cleared a source");

    mode_reserved_a: assert property (
        wr_c |=> (mode_c_r & ~swr_pkg::MODE_WR_MASK) == 32'h0 &&
        mode_c_r[30:28] == $past(wr_data_in[30:28]))
        else $error("Wake mode reserved bits mishandled");

    irq_level_a: assert property (
        |(irq_stat_r & irq_mask_r) |=> irq_out)
        else $error("Unmasked status did not raise interrupt");

    sequence cec_clear_quiet;
        clr_cec_tx && !cec_stat.hit;
    endsequence

    sequence rtc_both_rise;
        rtc_wake_en && rtc_wake_level_sel == swr_pkg::LVL_BOTH &&
        $rose(rtc_interrupt_in);
    endsequence

    sequence cec_both_fall;
        cec_tx_wake_en && cec_tx_wake_level_sel == swr_pkg::LVL_BOTH &&
        $fell(cec_transmit_interrupt_in);
    endsequence

    irq_quiet_a: assert property (
        (irq_stat_r & irq_mask_r) == 4'h0 |=> !irq_out)
        else $error("Interrupt high with no unmasked status");

    rtc_rise_seen_a: assert property (
        rtc_both_rise |=> rtc_wake_edge_seen == swr_pkg::SEEN_RISE)
        else $error("RTC rising edge not recorded");

    cec_fall_seen_a: assert property (
        cec_both_fall |=> cec_tx_wake_edge_seen == swr_pkg::SEEN_FALL)
        else $error("CEC transmit falling edge not recorded");

    cec_clear_seen_a: assert property (
        cec_clear_quiet |=> !cec_stat.pending &&
        cec_stat.edge_seen == swr_pkg::SEEN_NONE ##1 !cec_tx_wake_req_out)
        else $error("CEC transmit clear left request or edge record");

    clear_one_hot_a: assert property (
        $onehot0(other_clear_out))
        else $error("Several clear pulses at once");

    rtc_req_out_a: assert property (
        rtc_stat.hit |=> ##1 rtc_wake_req_out)
        else $error("RTC hit did not raise the wake request");

    cec_req_out_a: assert property (
        cec_stat.hit |=> ##1 cec_tx_wake_req_out)
        else $error("CEC transmit hit did not raise the wake request");

    nmi_stat_set_a: assert property (
        nmi_pin_in |=> irq_stat_r[swr_pkg::IRQ_NMI_PIN])
        else $error("NMI pin event missing from status");

    read_idle_zero_a: assert property (
        !rd_en_in |=> rd_data_out == 32'h0)
        else $error("Read data not zero outside a read");
endmodule

// file: verif/swr_src_model.sv
// Purpose: Far-side model of the wake and NMI request sources
// Assumes: Lines are synchronous to ref_clk_in
// Notes: Bit 0 RTC, 1 CEC transmit, 2 NMI pin, 3 watchdog
`timescale 1ns/1ps
module swr_src_model (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic [3:0] req_in,
    input wire logic slow_in,
    output logic [3:0] line_out
);
    logic [3:0] stage_r;
    logic [3:0] late_r;
    // Lines held low in reset so no false edge reaches the detectors
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage_r <= 4'h0;
            late_r <= 4'h0;
        end else begin
            stage_r <= req_in;
            late_r <= stage_r;
        end
    end
    // Slow mode adds a cycle; only switched while the lines are steady
    assign line_out = slow_in ? late_r : stage_r;
endmodule

// file: verif/tb_top.sv
// Purpose: Self-checking bench for the standby wake request control
// Assumes: Register port with one-cycle read latency
// Notes: Seeded random mode writes mixed with directed corner cases
`timescale 1ns/1ps
module tb_top;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [3:0] req = 4'h0;
    logic slow = 1'b0;
    logic [3:0] line;
    logic [31:0] rd_data;
    logic rtc_req;
    logic cec_req;
    logic [6:0] oclr;
    logic irq;
    logic [31:0] d;
    logic [31:0] v;
    int n_errors = 0;
    int n_tests = 0;
    integer seed = 70;
    always #5 ref_clk_in = ~ref_clk_in;
    swr_src_model src (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .req_in(req), .slow_in(slow), .line_out(line));
    swr_ctrl dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en),
        .rd_en_in(rd_en), .rtc_interrupt_in(line[0]),
        .cec_transmit_interrupt_in(line[1]), .nmi_pin_in(line[2]),
        .nmi_watchdog_in(line[3]), .rd_data_out(rd_data),
        .rtc_wake_req_out(rtc_req), .cec_tx_wake_req_out(cec_req),
        .other_clear_out(oclr), .irq_out(irq));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("Checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] x);
        @(posedge ref_clk_in);
        addr <= a;
        wdata <= x;
        wr_en <= 1'b1;
        @(posedge ref_clk_in);
        wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_in);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk_in);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic drive(input logic [3:0] x);
        @(posedge ref_clk_in);
        req <= x;
        repeat (5) @(posedge ref_clk_in);
        #1;
    endtask
    // Moves the lines, then checks pending and the edge record
    task automatic wake(input logic [7:0] a, input logic [3:0] x,
        input logic [31:0] mode, input logic exp, input logic [1:0] seen);
        drive(x);
        chk(a == swr_pkg::ADDR_WAKE_C ? rtc_req : cec_req, exp);
        rd(a);
        chk(d, mode | {28'h0, seen, 2'b00});
    endtask
    function automatic logic [6:0] exp_oclr(input logic [4:0] c);
        if (c <= 5'h04) return 7'h01 << c;
        if (c == swr_pkg::CLR_CEC_RX) return 7'h20;
        if (c == swr_pkg::CLR_REMOTE_RX) return 7'h40;
        return 7'h00;
    endfunction
    initial begin
        repeat (50000) @(posedge ref_clk_in);
        n_errors++;
        test_done;
    end
    initial begin
        repeat (8) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        rd(swr_pkg::ADDR_WAKE_C);
        chk(d, swr_pkg::MODE_RESET);
        @(posedge ref_clk_in);
        #1 chk(rd_data, 32'h0);
        rd(swr_pkg::ADDR_WAKE_D);
        chk(d, swr_pkg::MODE_RESET);
        rd(swr_pkg::ADDR_CLEAR);
        chk(d, 32'h0);
        rd(8'h20);
        chk(d, 32'h0);
        // Single writable bits 24, 16 and 8 are only ever written as zero
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 32'hfefe_feff : $random(seed) & 32'hfefe_feff;
            wr(i[0] ? swr_pkg::ADDR_WAKE_D : swr_pkg::ADDR_WAKE_C, v);
            rd(i[0] ? swr_pkg::ADDR_WAKE_D : swr_pkg::ADDR_WAKE_C);
            chk(d, v & swr_pkg::MODE_WR_MASK);
        end
        // Random modes may leave level hits pending, so start clean
        wr(swr_pkg::ADDR_WAKE_C, 32'h41);
        wr(swr_pkg::ADDR_WAKE_D, 32'h20);
        wr(swr_pkg::ADDR_CLEAR, 32'h8);
        wr(swr_pkg::ADDR_CLEAR, 32'hc);
        wr(swr_pkg::ADDR_IRQ_STAT, 32'hf);
        slow <= 1'b1;
        wake(swr_pkg::ADDR_WAKE_C, 4'h1, 32'h41, 1'b1, 2'b01);
        rd(swr_pkg::ADDR_IRQ_STAT);
        chk(d, 32'h1);
        chk(irq, 1'b0);
        wr(swr_pkg::ADDR_IRQ_MASK, 32'h1);
        @(posedge ref_clk_in);
        #1 chk(irq, 1'b1);
        wr(swr_pkg::ADDR_CLEAR, 32'h8);
        wake(swr_pkg::ADDR_WAKE_C, 4'h1, 32'h41, 1'b0, 2'b00);
        wr(swr_pkg::ADDR_IRQ_STAT, 32'h1);
        @(posedge ref_clk_in);
        #1 chk(irq, 1'b0);
        wake(swr_pkg::ADDR_WAKE_C, 4'h0, 32'h41, 1'b1, 2'b10);
        slow <= 1'b0;
        wr(swr_pkg::ADDR_WAKE_C, 32'h21);
        wr(swr_pkg::ADDR_CLEAR, 32'h8);
        wake(swr_pkg::ADDR_WAKE_C, 4'h1, 32'h21, 1'b0, 2'b00);
        wake(swr_pkg::ADDR_WAKE_C, 4'h0, 32'h21, 1'b1, 2'b00);
        // Prohibited codes above 0_1100 are never written
        for (int c = 0; c <= 12; c++) begin
            wr(swr_pkg::ADDR_CLEAR, c);
            chk(oclr, exp_oclr(c[4:0]));
            chk(rtc_req, c <= 8);
        end
        wr(swr_pkg::ADDR_WAKE_D, 32'h31);
        wake(swr_pkg::ADDR_WAKE_D, 4'h2, 32'h31, 1'b1, 2'b00);
        // Both wake sources have now hit since the last status clear
        rd(swr_pkg::ADDR_IRQ_STAT);
        chk(d, 32'h3);
        wr(swr_pkg::ADDR_CLEAR, 32'hc);
        wr(swr_pkg::ADDR_WAKE_D, 32'h41);
        wake(swr_pkg::ADDR_WAKE_D, 4'h0, 32'h41, 1'b1, 2'b10);
        wr(swr_pkg::ADDR_CLEAR, 32'hc);
        wake(swr_pkg::ADDR_WAKE_D, 4'h0, 32'h41, 1'b0, 2'b00);
        wr(swr_pkg::ADDR_WAKE_D, 32'h30);
        wake(swr_pkg::ADDR_WAKE_D, 4'h2, 32'h30, 1'b0, 2'b00);
        drive(4'h0);
        wr(swr_pkg::ADDR_IRQ_STAT, 32'hf);
        drive(4'h4);
        drive(4'h0);
        rd(swr_pkg::ADDR_NMI);
        chk(d, 32'h2);
        rd(swr_pkg::ADDR_NMI);
        chk(d, 32'h0);
        drive(4'hc);
        drive(4'h0);
        rd(swr_pkg::ADDR_NMI);
        chk(d, 32'h3);
        rd(swr_pkg::ADDR_IRQ_STAT);
        chk(d, 32'hc);
        chk(irq, 1'b0);
        wr(swr_pkg::ADDR_IRQ_MASK, 32'hc);
        @(posedge ref_clk_in);
        #1 chk(irq, 1'b1);
        // Plain level modes keep requesting while the line stays active
        wr(swr_pkg::ADDR_WAKE_C, 32'h11);
        wake(swr_pkg::ADDR_WAKE_C, 4'h1, 32'h11, 1'b1, 2'b00);
        wr(swr_pkg::ADDR_WAKE_C, 32'h01);
        wr(swr_pkg::ADDR_CLEAR, 32'h8);
        wake(swr_pkg::ADDR_WAKE_C, 4'h1, 32'h01, 1'b0, 2'b00);
        wake(swr_pkg::ADDR_WAKE_C, 4'h0, 32'h01, 1'b1, 2'b00);
        // Reset in mid-run while a request and an interrupt are up
        rst_n_in <= 1'b0;
        @(posedge ref_clk_in);
        #1 chk(rtc_req, 1'b0);
        chk(irq, 1'b0);
        chk(oclr, 7'h00);
        rst_n_in <= 1'b1;
        rd(swr_pkg::ADDR_WAKE_C);
        chk(d, swr_pkg::MODE_RESET);
        rd(swr_pkg::ADDR_IRQ_STAT);
        chk(d, 32'h0);
        test_done;
    end
endmodule
